// >>> hdl/port_six_pkg.sv
// constants, field layout and carrier types of the seven-pin shared bus port
// assumes a 32-bit apb slave; every register sits at four times its index
package port_six_pkg;
	// apb byte address width, wide enough for index times four
	localparam int ADDR_W = 18;
	// register indices, byte address is index times four
	localparam logic [15:0] DIR_IDX = 16'hffc9;
	localparam logic [15:0] DATA_IDX = 16'hffcb;
	localparam logic [15:0] CTRL_IDX = 16'hff40;
	// reset and read-back values
	localparam logic [7:0] DIR_RST = 8'h80;
	localparam logic [7:0] DATA_RST = 8'h80;
	localparam logic [7:0] DIR_READ = 8'hff;
	localparam logic [7:0] WCE_RST = 8'hff;
	localparam logic [7:0] WCE_ALL = 8'hff;
	localparam logic [2:0] MODE_EXP_LO = 3'h1;
	localparam logic [2:0] MODE_EXP_HI = 3'h5;
	localparam logic [2:0] MODE_RST = 3'h7;
	// pin positions
	localparam int PIN_ACK = 2;
	localparam int PIN_REQ = 1;
	localparam int PIN_WAIT = 0;
	localparam int DATA_RSV = 7;
	// control register field positions
	localparam int CTRL_BRE = 0;
	localparam int CTRL_WCE_LO = 8;
	localparam int CTRL_WCE_HI = 15;
	localparam int CTRL_WMS = 16;

	// bus strobes in pin order 6 down to 3, all active low
	typedef struct packed {
		logic low_byte_write_strobe_n;
		logic high_byte_write_strobe_n;
		logic read_strobe_n;
		logic address_strobe_n;
	} bus_strobes_t;

	// whole state of the port
	typedef struct packed {
		logic [7:0] dir;
		logic [7:0] data;
		logic bre;
		logic [7:0] wce;
		logic wms;
		logic [31:0] rdata;
		logic slverr;
		logic [6:0] pin_s1;
		logic [6:0] pin_s2;
		logic [2:0] mode_s1;
		logic [2:0] mode_s2;
		logic hsn_s1;
		logic hsn_s2;
	} state_t;

	localparam state_t ST_RST = '{dir: DIR_RST, data: DATA_RST, bre: 1'h0, wce: WCE_RST,
		wms: 1'h0, rdata: 32'h0000_0000, slverr: 1'h0, pin_s1: 7'h00, pin_s2: 7'h00,
		mode_s1: MODE_RST, mode_s2: MODE_RST, hsn_s1: 1'h1, hsn_s2: 1'h1};

	// byte address of a register index
	function automatic logic [ADDR_W-1:0] reg_addr(input logic [15:0] idx);
		return {idx, 2'b00};
	endfunction
endpackage

// >>> hdl/port_six.sv
// seven-pin i/o port shared with external bus control strobes, apb register slave
// assumes strobes, release acknowledge and software standby come from logic on pclk;
// pins, mode pins and the hardware standby pin are asynchronous and are synchronised here
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module port_six
	import port_six_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	input wire logic [2:0] mode_pins,
	input wire logic hw_standby_n,
	input wire logic sw_standby,
	input wire bus_strobes_t strobes,
	input wire logic bus_release_ack_n,
	output logic bus_release_request_n,
	output logic wait_request_n,
	input wire logic [6:0] pin_in,
	output logic [6:0] pin_out,
	output logic [6:0] pin_oe
);

	state_t st_r;
	state_t st_nxt;
	logic expanded;
	logic hw_standby;
	logic wait_general;
	logic setup;
	logic wr_ok;
	logic hit_dir;
	logic hit_data;
	logic hit_ctrl;

	// value seen by software on a port read, per pin
	function automatic logic [6:0] port_read(input logic [6:0] dir, input logic [6:0] dat,
		input logic [6:0] lvl);
		return (dir & dat) | (~dir & lvl);
	endfunction

	// mode and standby decode from the synchronised pins
	// mode 0 counts as single-chip; only modes 1 to 5 open the external bus
	assign expanded = (st_r.mode_s2 >= MODE_EXP_LO) && (st_r.mode_s2 <= MODE_EXP_HI);
	assign hw_standby = ~st_r.hsn_s2;
	assign wait_general = (st_r.wce == WCE_ALL) && !st_r.wms;

	// address decode
	assign setup = psel && !penable;
	assign hit_dir = (paddr == reg_addr(DIR_IDX));
	assign hit_data = (paddr == reg_addr(DATA_IDX));
	assign hit_ctrl = (paddr == reg_addr(CTRL_IDX));
	// writes are dropped while the chip sleeps, so contents survive software standby; hardware standby reloads reset values
	assign wr_ok = psel && penable && pwrite && !sw_standby && !hw_standby;

	// no wait states; read data is caught in the setup cycle
	assign pready = 1'h1;
	assign prdata = st_r.rdata;
	assign pslverr = st_r.slverr && psel && penable;

	// next-state logic
	always_comb begin
		st_nxt = st_r;
		// two-stage synchronisers
		// the first stage feeds only the second, keeping metastability out of the decode
		st_nxt.pin_s1 = pin_in;
		st_nxt.pin_s2 = st_r.pin_s1;
		st_nxt.mode_s1 = mode_pins;
		st_nxt.mode_s2 = st_r.mode_s1;
		st_nxt.hsn_s1 = hw_standby_n;
		st_nxt.hsn_s2 = st_r.hsn_s1;
		// read data and error flag latched at setup
		if (setup) begin
			st_nxt.slverr = !(hit_dir || hit_data || hit_ctrl);
			st_nxt.rdata = 32'h0000_0000;
			if (hit_dir) begin
				st_nxt.rdata[7:0] = DIR_READ;
			end
			if (hit_data) begin
				st_nxt.rdata[6:0] = port_read(st_r.dir[6:0], st_r.data[6:0], st_r.pin_s2);
				st_nxt.rdata[DATA_RSV] = st_r.data[DATA_RSV];
			end
			if (hit_ctrl) begin
				st_nxt.rdata[CTRL_BRE] = st_r.bre;
				st_nxt.rdata[CTRL_WCE_HI:CTRL_WCE_LO] = st_r.wce;
				st_nxt.rdata[CTRL_WMS] = st_r.wms;
			end
		end
		if (wr_ok && hit_dir && pstrb[0]) begin
			st_nxt.dir = pwdata[7:0];
		end
		if (wr_ok && hit_data && pstrb[0]) begin
			st_nxt.data = {st_r.data[DATA_RSV], pwdata[6:0]};
		end
		// control bits stand in for the bus-release and wait units
		if (wr_ok && hit_ctrl) begin
			if (pstrb[0]) begin
				st_nxt.bre = pwdata[CTRL_BRE];
			end
			if (pstrb[1]) begin
				st_nxt.wce = pwdata[CTRL_WCE_HI:CTRL_WCE_LO];
			end
			if (pstrb[2]) begin
				st_nxt.wms = pwdata[CTRL_WMS];
			end
		end
		if (hw_standby) begin
			st_nxt.dir = DIR_RST;
			st_nxt.data = DATA_RST;
			st_nxt.bre = ST_RST.bre;
			st_nxt.wce = WCE_RST;
			st_nxt.wms = ST_RST.wms;
		end
	end

	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= ST_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// pin function select
	always_comb begin
		pin_out = st_r.data[6:0];
		// direction alone decides drive here, software standby or not; hardware standby below releases every pin
		pin_oe = st_r.dir[6:0];
		if (expanded) begin
			// strobes pass unregistered so they stay in step with the bus cycle
			// strobes override direction
			pin_out[6:3] = strobes;
			pin_oe[6:3] = 4'hf;
			if (st_r.bre) begin
				pin_out[PIN_ACK] = bus_release_ack_n;
				pin_oe[PIN_ACK] = 1'h1;
				pin_oe[PIN_REQ] = 1'h0;
			end
			if (!wait_general) begin
				pin_oe[PIN_WAIT] = 1'h0;
			end
		end
		// hardware standby releases every pin
		if (hw_standby) begin
			pin_oe = 7'h00;
		end
	end

	// alternate inputs to the bus controller
	assign bus_release_request_n = (expanded && st_r.bre) ? st_r.pin_s2[PIN_REQ] : 1'h1;
	assign wait_request_n = (expanded && !wait_general) ? st_r.pin_s2[PIN_WAIT] : 1'h1;

	// checks on the register file and on pin functions
	a_dir_read_ones: assert property (@(posedge pclk) disable iff (!presetn)
		psel && penable && !pwrite && hit_dir |-> prdata == 32'h0000_00ff)
		else $error("direction read not all ones");

	a_dir_write_load: assert property (@(posedge pclk) disable iff (!presetn)
		wr_ok && hit_dir && pstrb[0] |=> st_r.dir == $past(pwdata[7:0]))
		else $error("direction write lost");

	a_hw_standby_load: assert property (@(posedge pclk) disable iff (!presetn)
		hw_standby |=> st_r.dir == DIR_RST && st_r.data == DATA_RST)
		else $error("hardware standby did not reload");

	a_sw_standby_hold: assert property (@(posedge pclk) disable iff (!presetn)
		sw_standby && !hw_standby |=> $stable(st_r.dir) && $stable(st_r.data))
		else $error("registers changed in software standby");

	a_sw_standby_drive: assert property (@(posedge pclk) disable iff (!presetn)
		sw_standby && !hw_standby && !expanded |-> pin_oe == st_r.dir[6:0])
		else $error("pin released in software standby");

	a_data_write: assert property (@(posedge pclk) disable iff (!presetn)
		wr_ok && hit_data && pstrb[0] |=> st_r.data[6:0] == $past(pwdata[6:0]))
		else $error("data write lost");

	a_port_read: assert property (@(posedge pclk) disable iff (!presetn)
		setup && !pwrite && hit_data |=>
		prdata[6:0] == port_read($past(st_r.dir[6:0]), $past(st_r.data[6:0]),
		$past(st_r.pin_s2)))
		else $error("port read value wrong");

	a_data_bit7: assert property (@(posedge pclk) disable iff (!presetn)
		psel && penable && !pwrite && hit_data |-> prdata[DATA_RSV])
		else $error("reserved data bit read zero");

	a_strobe_drive: assert property (@(posedge pclk) disable iff (!presetn)
		expanded && !hw_standby |-> pin_oe[6:3] == 4'hf && pin_out[6:3] == strobes)
		else $error("strobe pins not driven");

	a_single_chip: assert property (@(posedge pclk) disable iff (!presetn)
		!expanded && !hw_standby |-> pin_oe == st_r.dir[6:0] && pin_out == st_r.data[6:0])
		else $error("single-chip pin not general");

	a_release_pins: assert property (@(posedge pclk) disable iff (!presetn)
		expanded && st_r.bre && !hw_standby |->
		pin_oe[2:1] == 2'h2 && pin_out[PIN_ACK] == bus_release_ack_n)
		else $error("release pins wrong");

	a_release_req: assert property (@(posedge pclk) disable iff (!presetn)
		expanded && st_r.bre ##2 expanded && st_r.bre && $stable(pin_in) |->
		bus_release_request_n == $past(pin_in[PIN_REQ], 2))
		else $error("release request not passed");

	a_wait_input: assert property (@(posedge pclk) disable iff (!presetn)
		expanded && !wait_general |-> !pin_oe[PIN_WAIT] &&
		wait_request_n == st_r.pin_s2[PIN_WAIT])
		else $error("wait pin not an input");

	a_general_out: assert property (@(posedge pclk) disable iff (!presetn)
		expanded && !st_r.bre && !hw_standby && st_r.dir[PIN_ACK] |->
		pin_oe[PIN_ACK] && pin_out[PIN_ACK] == st_r.data[PIN_ACK])
		else $error("general output not driven from data");

	a_general_pin0: assert property (@(posedge pclk) disable iff (!presetn)
		expanded && wait_general && !hw_standby |-> pin_oe[PIN_WAIT] == st_r.dir[PIN_WAIT])
		else $error("pin 0 direction ignored");

	// checks on pin functions in both modes and both standbys, and on the reserved data bit
	a_hw_standby_float: assert property (@(posedge pclk) disable iff (!presetn)
		hw_standby |-> pin_oe == 7'h00)
		else $error("pin driven in hardware standby");

	a_data_rsv_set: assert property (@(posedge pclk) disable iff (!presetn)
		st_r.data[DATA_RSV])
		else $error("reserved data bit cleared");

	a_single_inputs: assert property (@(posedge pclk) disable iff (!presetn)
		!expanded |-> bus_release_request_n && wait_request_n)
		else $error("bus inputs claimed in single-chip mode");

	a_general_pin1: assert property (@(posedge pclk) disable iff (!presetn)
		expanded && !st_r.bre && !hw_standby |->
		pin_oe[PIN_REQ] == st_r.dir[PIN_REQ] && bus_release_request_n)
		else $error("pin 1 not general with release off");

	a_general_pin2: assert property (@(posedge pclk) disable iff (!presetn)
		expanded && !st_r.bre && !hw_standby |-> pin_oe[PIN_ACK] == st_r.dir[PIN_ACK])
		else $error("pin 2 not general with release off");

	a_pin0_value: assert property (@(posedge pclk) disable iff (!presetn)
		expanded && wait_general && !hw_standby && st_r.dir[PIN_WAIT] |->
		pin_out[PIN_WAIT] == st_r.data[PIN_WAIT])
		else $error("pin 0 output not from data");

	a_wait_idle: assert property (@(posedge pclk) disable iff (!presetn)
		expanded && wait_general |-> wait_request_n)
		else $error("wait request passed while pin 0 is general");

	a_sw_drive_general: assert property (@(posedge pclk) disable iff (!presetn)
		sw_standby && !hw_standby && expanded && !st_r.bre && wait_general |->
		pin_oe[PIN_ACK:PIN_WAIT] == st_r.dir[PIN_ACK:PIN_WAIT])
		else $error("general pin released in software standby");

	// main scenarios
	c_port_read: cover property (@(posedge pclk) disable iff (!presetn)
		psel && penable && !pwrite && hit_data);
	c_sw_standby: cover property (@(posedge pclk) disable iff (!presetn)
		sw_standby && st_r.dir[6:0] != 7'h00);
	c_release_on: cover property (@(posedge pclk) disable iff (!presetn)
		expanded && st_r.bre && !bus_release_request_n);
	c_wait_active: cover property (@(posedge pclk) disable iff (!presetn)
		expanded && !wait_general && !wait_request_n);
	c_hw_standby: cover property (@(posedge pclk) disable iff (!presetn)
		hw_standby);

endmodule
`default_nettype wire

// >>> tb/pin_partner.sv
// far-side pin model: external parts that listen to and drive the port pins
// assumes one level per pin; the device's drive wins where it drives
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
	input wire logic [6:0] pin_out,
	input wire logic [6:0] pin_oe,
	input wire logic [6:0] ext,
	output logic [6:0] pin_in
);
	// wire level seen by every input
	// driven pin value where enabled, external level elsewhere
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule
`default_nettype wire

// >>> tb/bus_control_shared_io_port_bench.sv
// self-checking bench of the shared bus port, apb master tasks and pin model
// assumes port_six and its package compiled before this file
`timescale 1ns/1ps
`default_nettype none
module bus_control_shared_io_port_bench;
	import port_six_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic [3:0] pstrb = 4'hf;
	logic pready, pslverr, req_n, wait_n;
	logic [2:0] mode_pins = 3'h7;
	logic hw_standby_n = 1, sw_standby = 0, ack_n = 0;
	bus_strobes_t strobes = 4'ha;
	logic [6:0] pin_in, pin_out, pin_oe, ext = 7'h55;
	int err_total = 0, checked = 0;
	// clock
	always #20 pclk = ~pclk;
	port_six u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .mode_pins(mode_pins),
		.hw_standby_n(hw_standby_n), .sw_standby(sw_standby), .strobes(strobes),
		.bus_release_ack_n(ack_n), .bus_release_request_n(req_n),
		.wait_request_n(wait_n), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
	pin_partner u_pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext(ext), .pin_in(pin_in));
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		checked++;
		if (g !== x) begin
			err_total++;
			$display("[FAIL] %0t got %h want %h", $time, g, x);
		end
	endtask
	// one apb transfer, held until pready is seen high
	task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge pclk);
		@(negedge pclk);
	endtask
	task automatic t_reset;
		apb(0, DIR_IDX, 0);
		chk(rd[7:0], 8'hff);
		apb(0, DATA_IDX, 0);
		chk(rd[7:0], 8'hd5);
		chk(pin_oe, 0);
		apb(0, 16'h0000, 0);
		chk(er, 1);
	endtask
	task automatic t_single;
		apb(1, DIR_IDX, 8'h0f);
		apb(1, DATA_IDX, 8'h0a);
		apb(0, DATA_IDX, 0);
		chk(rd[7:0], 8'hda);
		wt(1);
		chk(pin_oe, 7'h0f);
		chk(pin_out[3:0], 4'ha);
		chk({req_n, wait_n}, 2'b11);
	endtask
	task automatic t_expanded;
		@(posedge pclk);
		mode_pins <= 3'h3;
		wt(3);
		chk({pin_oe[6:3], pin_out[6:3]}, 8'hfa);
		@(posedge pclk);
		strobes <= 4'h5;
		wt(1);
		chk(pin_out[6:3], 4'h5);
		chk({pin_oe[2:0], pin_out[2:0]}, 6'h3a);
		apb(1, CTRL_IDX, 32'h0000_ff01);
		ext <= 7'h00;
		wt(3);
		chk({pin_oe[2:0], pin_out[2], req_n}, 5'h14);
		@(posedge pclk);
		ext <= 7'h02;
		ack_n <= 1'b1;
		wt(3);
		chk(req_n, 1);
		chk(pin_out[PIN_ACK], 1'b1);
		// wait input kept at direction zero
		apb(1, DIR_IDX, 8'h0e);
		apb(1, CTRL_IDX, 32'h0000_fe00);
		wt(3);
		chk({pin_oe[0], wait_n}, 2'b00);
		apb(1, CTRL_IDX, 32'h0001_ff00);
		wt(3);
		chk({pin_oe[0], wait_n}, 2'b00);
		apb(1, CTRL_IDX, 32'h0000_ff00);
		wt(3);
		chk({pin_oe[2:0], wait_n}, 4'hd);
	endtask
	task automatic t_standby;
		@(posedge pclk);
		mode_pins <= 3'h7;
		ext <= 7'h55;
		wt(3);
		chk({pin_oe, pin_out[3:1]}, 10'h075);
		@(posedge pclk);
		sw_standby <= 1;
		apb(1, DATA_IDX, 8'h05);
		apb(1, DIR_IDX, 8'h00);
		wt(1);
		chk({pin_oe, pin_out[3:1]}, 10'h075);
		@(posedge pclk);
		sw_standby <= 0;
		hw_standby_n <= 0;
		wt(3);
		chk(pin_oe, 0);
		@(posedge pclk);
		hw_standby_n <= 1;
		wt(3);
		apb(0, DATA_IDX, 0);
		chk(rd[7:0], 8'hd5);
	endtask
	task automatic conclude;
		$display("mismatches %0d comparisons %0d", err_total, checked);
		if (err_total == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1;
		wt(3);
		t_reset();
		t_single();
		t_expanded();
		t_standby();
		conclude();
	end
	// watchdog
	initial begin
		#200000;
		err_total++;
		conclude();
	end
endmodule
`default_nettype wire
